/* rtl/pviu_consts.vh */
// constants for the prioritised vector interrupt unit
`ifndef PVIU_CONSTS_VH
`define PVIU_CONSTS_VH
// ==========================================================
// vectors and parameter area
`define PVIU_VEC_TRAP      8'h10
`define PVIU_VEC_NMI      8'h18
`define PVIU_VEC_MASK0    8'h20
`define PVIU_VEC_STEP     8'h08
`define PVIU_PARAM_BASE   16'hFF00
`define PVIU_PARAM_LO     16'hFF20
`define PVIU_PARAM_HI     16'hFF5F
`define PVIU_PARAM_BYTES  3'h6
// ==========================================================
// flag register
`define PVIU_FLAG_IEF     5
`define PVIU_FLAG_RST     8'h00
// ==========================================================
// timing: 20 states, one state per clk_sys cycle
`define PVIU_SEQ_STATES   5'h14
`define PVIU_NSRC         8
`define PVIU_ZERO8        8'h00
`define PVIU_ONE8         8'h01
`endif

/* rtl/pviu_core.v */
// interrupt acceptance, priority and vectoring for the 8-bit core
// How it works
// - after reset requests use general handling until dma enable is written
// - nmi and trap always taken; maskable ones only while enable flag is 1
// - requests sampled once per instruction at end of its last bus cycle
// - vector read happens internally; bus shows one dummy cycle meanwhile
// - general handling pushes pc and flag pair, clears flag, jumps to vector
// - accept to first handler fetch takes 20 states
// - return pops pc and flag pair, restoring the old enable flag
// - vector read acknowledges and clears the chosen source's request
// - enable flag is flag bit 5; enable sets it, disable clears it
// - reset and every accepted interrupt clear the enable flag
// - enable takes effect only after the following instruction completes
// - trap priority 1 vector 10H, nmi priority 2 vector 18H, no dma block
// - maskable sources priority 3..10 take vectors 20H..58H by eight
// - dma blocks run from FF20H for highest to FF58H for lowest maskable
// - FF20H..FF5FH is the dma parameter area, plain ram otherwise
// - only the highest simultaneous request passes; running one not compared
// - dma block for a source starts at FF00H plus vector, six bytes long
// - count decremented per dma transfer; zero falls into general handling
`timescale 1ns/10ps
`include "pviu_consts.vh"
module pviu_core (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // request pins, asynchronous edge events from outside
  input  wire        nmi_pin_request,
  input  wire        external_request_0,
  input  wire        external_request_1,
  // on-chip request pulses, same clock
  input  wire        timer0_request,
  input  wire        timer1_request,
  input  wire        timer2_request,
  input  wire        timer3_request,
  input  wire        serial_receive_done_request,
  input  wire        serial_transmit_done_request,
  input  wire        software_trap_instruction,
  // dma enable per maskable source, bit 0 is highest priority
  input  wire [7:0]  dma_enable,
  // core instruction events
  input  wire        last_bus_cycle_end,
  input  wire        enable_irq_instruction,
  input  wire        disable_irq_instruction,
  input  wire        irq_return_instruction,
  input  wire [7:0]  popped_flags,
  input  wire        dma_count_zero,
  input  wire        dma_done,
  // flag register view
  output reg  [7:0]  flag_q,
  output wire        irq_enable_flag,
  // acceptance and sequencing
  output reg         accept_q,
  output reg  [7:0]  vector_q,
  output reg         dma_mode_q,
  output reg  [15:0] param_addr_q,
  output reg  [2:0]  param_len_q,
  output reg         bus_dummy_q,
  output reg         push_pc_flags_q,
  output reg         pop_restore_q,
  output reg         jump_q,
  output reg  [15:0] jump_addr_q,
  output wire        busy
);

// ==========================================================
// pin synchronisers and edge detect
reg  [2:0]  pin_s1_q;
reg  [2:0]  pin_s2_q;
reg  [2:0]  pin_s3_q;
wire [2:0]  pin_rise;

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    pin_s1_q <= 3'h0;
    pin_s2_q <= 3'h0;
    pin_s3_q <= 3'h0;
  end else begin
    pin_s1_q <= {external_request_1, external_request_0, nmi_pin_request};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end
end

assign pin_rise = pin_s2_q & ~pin_s3_q;

// ==========================================================
// pending latches: trap, nmi, then maskable by priority
reg        trap_pend_q;
reg        nmi_pend_q;
reg  [7:0] mask_pend_q;
wire [7:0] mask_set;
reg        ack_trap;
reg        ack_nmi;
reg  [7:0] ack_mask;
reg        ei_hold_q;

assign mask_set = {serial_transmit_done_request,
                   serial_receive_done_request,
                   pin_rise[2],
                   timer3_request, timer2_request,
                   timer1_request, timer0_request,
                   pin_rise[1]};

// set wins over acknowledge so a fresh event is never dropped
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    trap_pend_q <= 1'b0;
    nmi_pend_q  <= 1'b0;
    mask_pend_q <= `PVIU_ZERO8;
  end else begin
    trap_pend_q <= software_trap_instruction |
                   (trap_pend_q & ~ack_trap);
    nmi_pend_q  <= pin_rise[0] | (nmi_pend_q & ~ack_nmi);
    mask_pend_q <= mask_set | (mask_pend_q & ~ack_mask);
  end
end

// ==========================================================
// priority selection
function [3:0] pick_lowest;
  input [7:0] req;
  integer i;
  begin
    pick_lowest = 4'h8;
    for (i = 7; i >= 0; i = i - 1)
      if (req[i])
        pick_lowest = i[3:0];
  end
endfunction

wire [7:0] mask_ok;
wire [3:0] mask_sel;
wire       any_take;

// maskable only counted while the flag allows and delay is over
assign mask_ok  = mask_pend_q &
                  {8{flag_q[`PVIU_FLAG_IEF] & ~ei_hold_q}};
assign mask_sel = pick_lowest(mask_ok);
assign any_take = trap_pend_q | nmi_pend_q | (mask_sel != 4'h8);

// ==========================================================
// acceptance sequence
localparam ST_IDLE  = 2'h0;
localparam ST_VEC   = 2'h1;
localparam ST_GEN   = 2'h2;
localparam ST_DMA   = 2'h3;

reg [1:0] st_q;
reg [4:0] cnt_q;
reg [1:0] sel_kind_q;  // 0 trap, 1 nmi, 2 maskable
reg [2:0] sel_idx_q;

assign irq_enable_flag = flag_q[`PVIU_FLAG_IEF];
assign busy            = (st_q != ST_IDLE);

function [7:0] vec_of;
  input [1:0] kind;
  input [2:0] idx;
  begin
    case (kind)
      2'h0:    vec_of = `PVIU_VEC_TRAP;
      2'h1:    vec_of = `PVIU_VEC_NMI;
      default: vec_of = `PVIU_VEC_MASK0 + {2'h0, idx, 3'h0};
    endcase
  end
endfunction

always @* begin
  ack_trap = 1'b0;
  ack_nmi  = 1'b0;
  ack_mask = `PVIU_ZERO8;
  if (st_q == ST_VEC) begin
    case (sel_kind_q)
      2'h0:    ack_trap = 1'b1;
      2'h1:    ack_nmi  = 1'b1;
      default: ack_mask = `PVIU_ONE8 << sel_idx_q;
    endcase
  end
end

always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    st_q            <= ST_IDLE;
    cnt_q           <= 5'h00;
    ei_hold_q       <= 1'b0;
    sel_kind_q      <= 2'h0;
    sel_idx_q       <= 3'h0;
    flag_q          <= `PVIU_FLAG_RST;
    accept_q        <= 1'b0;
    vector_q        <= `PVIU_ZERO8;
    dma_mode_q      <= 1'b0;
    param_addr_q    <= 16'h0000;
    param_len_q     <= 3'h0;
    bus_dummy_q     <= 1'b0;
    push_pc_flags_q <= 1'b0;
    pop_restore_q   <= 1'b0;
    jump_q          <= 1'b0;
    jump_addr_q     <= 16'h0000;
  end else begin
    accept_q        <= 1'b0;
    push_pc_flags_q <= 1'b0;
    pop_restore_q   <= 1'b0;
    jump_q          <= 1'b0;
    case (st_q)
      ST_IDLE: begin
        // enable/disable/return act in the cycle their input pulses, only while idle
        if (enable_irq_instruction) begin
          flag_q[`PVIU_FLAG_IEF] <= 1'b1;
          ei_hold_q              <= 1'b1;
        end else if (last_bus_cycle_end) begin
          ei_hold_q <= 1'b0;
        end
        if (disable_irq_instruction)
          flag_q[`PVIU_FLAG_IEF] <= 1'b0;
        if (irq_return_instruction) begin
          flag_q        <= popped_flags;
          pop_restore_q <= 1'b1;
        end
        // sampled only at the end of an instruction's last bus cycle
        if (last_bus_cycle_end && any_take &&
            !enable_irq_instruction) begin
          accept_q               <= 1'b1;
          flag_q[`PVIU_FLAG_IEF] <= 1'b0;
          st_q                   <= ST_VEC;
          cnt_q                  <= 5'h01;
          bus_dummy_q            <= 1'b1;
          if (trap_pend_q) begin
            sel_kind_q <= 2'h0;
          end else if (nmi_pend_q) begin
            sel_kind_q <= 2'h1;
          end else begin
            sel_kind_q <= 2'h2;
            sel_idx_q  <= mask_sel[2:0];
          end
        end
      end
      ST_VEC: begin
        // internal vector read; the bus idles for one dummy cycle
        vector_q    <= vec_of(sel_kind_q, sel_idx_q);
        bus_dummy_q <= 1'b0;
        cnt_q       <= cnt_q + 5'h01;
        if (sel_kind_q == 2'h2 && dma_enable[sel_idx_q]) begin
          dma_mode_q   <= 1'b1;
          param_addr_q <= `PVIU_PARAM_BASE +
                          {8'h00, vec_of(sel_kind_q, sel_idx_q)};
          param_len_q  <= `PVIU_PARAM_BYTES;
          st_q         <= ST_DMA;
        end else begin
          dma_mode_q      <= 1'b0;
          push_pc_flags_q <= 1'b1;
          st_q            <= ST_GEN;
        end
      end
      ST_GEN: begin
        // pushes and vector load fill the fixed overhead
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == `PVIU_SEQ_STATES - 5'h01) begin
          jump_q      <= 1'b1;
          jump_addr_q <= {8'h00, vector_q};
          st_q        <= ST_IDLE;
          cnt_q       <= 5'h00;
        end
      end
      ST_DMA: begin
        // the core walks the parameter block and reports the count
        if (dma_done) begin
          dma_mode_q <= 1'b0;
          if (dma_count_zero) begin
            push_pc_flags_q <= 1'b1;
            cnt_q           <= 5'h02;
            st_q            <= ST_GEN;
          end else begin
            st_q  <= ST_IDLE;
            cnt_q <= 5'h00;
          end
        end
      end
      default: st_q <= ST_IDLE;
    endcase
  end
end

endmodule

/* tb/pviu_core_monitor.sv */
// concurrent checks on the interrupt unit ports
`timescale 1ns/10ps
module pviu_core_monitor (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_b,
  // core events
  input wire        last_bus_cycle_end,
  input wire        enable_irq_instruction,
  input wire        disable_irq_instruction,
  input wire        irq_return_instruction,
  input wire [7:0]  popped_flags,
  // unit outputs
  input wire [7:0]  flag_q,
  input wire        irq_enable_flag,
  input wire        accept_q,
  input wire [7:0]  vector_q,
  input wire        dma_mode_q,
  input wire [15:0] param_addr_q,
  input wire [2:0]  param_len_q,
  input wire        bus_dummy_q,
  input wire        push_pc_flags_q,
  input wire        jump_q,
  input wire [15:0] jump_addr_q,
  input wire        busy
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_dma_acc;
    accept_q ##1 dma_mode_q;
  endsequence
  property p_take;
    accept_q |-> $past(last_bus_cycle_end);
  endproperty
  property p_dummy;
    accept_q |-> bus_dummy_q && !irq_enable_flag;
  endproperty
  property p_vec;
    accept_q |=> vector_q[2:0] == 3'h0 && vector_q >= 8'h10
      && vector_q <= 8'h58;
  endproperty
  property p_jump20;
    push_pc_flags_q |-> ##18 jump_q;
  endproperty
  property p_jaddr;
    jump_q |-> jump_addr_q == {8'h00, vector_q};
  endproperty
  property p_param;
    s_dma_acc |-> param_addr_q == 16'hFF00 + {8'h00, vector_q}
      && param_len_q == 3'h6;
  endproperty
  property p_ei;
    enable_irq_instruction && !busy |=> irq_enable_flag;
  endproperty
  property p_di;
    disable_irq_instruction && !busy |=> !flag_q[5];
  endproperty
  property p_ret;
    irq_return_instruction && !busy |=> flag_q == $past(popped_flags);
  endproperty
  // ==========================================================
  // assertions
  a_take: assert property (p_take) else $error("accept off sample");
  a_dummy: assert property (p_dummy) else $error("no dummy cycle");
  a_vec: assert property (p_vec) else $error("vector illegal");
  a_jump20: assert property (p_jump20) else $error("jump late");
  a_jaddr: assert property (p_jaddr) else $error("jump addr");
  a_param: assert property (p_param) else $error("param block");
  a_ei: assert property (p_ei) else $error("enable not set");
  a_di: assert property (p_di) else $error("enable not clear");
  a_ret: assert property (p_ret) else $error("flags not back");
endmodule

/* tb/pviu_cpu_model.sv */
// core side model: runs micro dma transfers after a dma accept
`timescale 1ns/10ps
module pviu_cpu_model (
  // clock and reset
  input  wire      clk_sys,
  input  wire      rst_b,
  // unit side
  input  wire      accept_q,
  input  wire      dma_mode_q,
  input  wire      zero_sel,
  output reg       dma_done,
  output reg       dma_count_zero
);
  reg       run_q;
  reg [3:0] cnt_q;
  // ==========================================================
  // one transfer takes some cycles, then count result reported
  always @(negedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      cnt_q <= 4'h0;
      dma_done <= 1'b0;
      dma_count_zero <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      dma_count_zero <= ~zero_sel;
      if (accept_q) begin
        run_q <= 1'b1;
        cnt_q <= 4'h7;
      end else if (run_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (run_q) begin
        run_q <= 1'b0;
        dma_done <= dma_mode_q;
        dma_count_zero <= zero_sel;
      end
    end
  end
endmodule

/* tb/tb_prioritised_vector_interrupt_unit.sv */
// self-checking bench for the interrupt unit
`timescale 1ns/10ps
module tb_prioritised_vector_interrupt_unit;
  reg clk_sys = 0, rst_b = 0, nmi_pin_request = 0, zero_sel = 0;
  reg external_request_0 = 0, external_request_1 = 0;
  reg timer0_request = 0, timer1_request = 0, timer2_request = 0;
  reg timer3_request = 0, serial_receive_done_request = 0;
  reg serial_transmit_done_request = 0, software_trap_instruction = 0;
  reg last_bus_cycle_end = 0, enable_irq_instruction = 0;
  reg disable_irq_instruction = 0, irq_return_instruction = 0;
  reg [7:0] dma_enable = 8'h00, popped_flags = 8'h00;
  wire dma_done, dma_count_zero, irq_enable_flag, accept_q, dma_mode_q;
  wire bus_dummy_q, push_pc_flags_q, pop_restore_q, jump_q, busy;
  wire [7:0] flag_q, vector_q;
  wire [15:0] param_addr_q, jump_addr_q;
  wire [2:0] param_len_q;
  int error_cnt = 0, total_checks = 0, i;
  pviu_core dut (.clk_sys, .rst_b, .nmi_pin_request, .external_request_0,
    .external_request_1, .timer0_request, .timer1_request,
    .timer2_request, .timer3_request, .serial_receive_done_request,
    .serial_transmit_done_request, .software_trap_instruction,
    .dma_enable, .last_bus_cycle_end, .enable_irq_instruction,
    .disable_irq_instruction, .irq_return_instruction, .popped_flags,
    .dma_count_zero, .dma_done, .flag_q, .irq_enable_flag, .accept_q,
    .vector_q, .dma_mode_q, .param_addr_q, .param_len_q, .bus_dummy_q,
    .push_pc_flags_q, .pop_restore_q, .jump_q, .jump_addr_q, .busy);
  pviu_cpu_model cpu (.clk_sys, .rst_b, .accept_q, .dma_mode_q,
    .zero_sel, .dma_done, .dma_count_zero);
  always #50 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  task final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one instruction end; accept stands only in the cycle after the sample
  task instr(input logic [7:0] v);
    last_bus_cycle_end = 1;
    cyc(1);
    last_bus_cycle_end = 0;
    chk("accept", {15'h0, v != 8'h00}, {15'h0, accept_q});
    cyc(1);
    if (v != 8'h00) chk("vector", {8'h00, v}, {8'h00, vector_q});
  endtask
  task wait_idle;
    for (i = 0; i < 60 && busy !== 1'b0; i++) cyc(1);
    if (busy !== 1'b0) begin
      error_cnt++;
      final_report;
    end
  endtask
  task arm_ei;
    enable_irq_instruction = 1;
    cyc(1);
    enable_irq_instruction = 0;
    instr(8'h00);
  endtask
  // ==========================================================
  // scenarios
  task t_mask;
    timer0_request = 1;
    cyc(1);
    timer0_request = 0;
    instr(8'h00);
    arm_ei();
    instr(8'h28);
    chk("flag", 16'h0000, {8'h00, flag_q});
    wait_idle();
    chk("jump addr", 16'h0028, jump_addr_q);
  endtask
  task t_prio;
    {external_request_0, external_request_1} = 2'b11;
    {timer0_request, timer1_request, timer2_request} = 3'b111;
    {timer3_request, serial_receive_done_request} = 2'b11;
    serial_transmit_done_request = 1;
    cyc(1);
    {timer0_request, timer1_request, timer2_request} = 3'b000;
    {timer3_request, serial_receive_done_request} = 2'b00;
    serial_transmit_done_request = 0;
    cyc(4);
    for (int k = 0; k < 8; k++) begin
      arm_ei();
      instr(8'h20 + 8'h08 * k[7:0]);
      wait_idle();
    end
    {external_request_0, external_request_1} = 2'b00;
  endtask
  task t_nmi;
    {software_trap_instruction, nmi_pin_request} = 2'b11;
    cyc(1);
    software_trap_instruction = 0;
    cyc(4);
    instr(8'h10);
    wait_idle();
    instr(8'h18);
    wait_idle();
    nmi_pin_request = 0;
  endtask
  task t_di_ret;
    arm_ei();
    disable_irq_instruction = 1;
    cyc(1);
    disable_irq_instruction = 0;
    timer1_request = 1;
    cyc(1);
    timer1_request = 0;
    instr(8'h00);
    popped_flags = 8'h20;
    irq_return_instruction = 1;
    cyc(1);
    irq_return_instruction = 0;
    chk("pop", 16'h0001, {15'h0, pop_restore_q});
    cyc(1);
    chk("flags", 16'h0020, {8'h00, flag_q});
    instr(8'h30);
    wait_idle();
  endtask
  task t_dma(input logic z);
    logic seen;
    seen = 0;
    zero_sel = z;
    dma_enable = 8'h02;
    timer0_request = 1;
    cyc(1);
    timer0_request = 0;
    arm_ei();
    instr(8'h28);
    chk("dma mode", 16'h0001, {15'h0, dma_mode_q});
    chk("param", 16'hFF28, param_addr_q);
    chk("len", 16'h0006, {13'h0, param_len_q});
    for (int k = 0; k < 60; k++) begin
      if (jump_q === 1'b1) seen = 1;
      cyc(1);
    end
    chk("dma jump", {15'h0, z}, {15'h0, seen});
    dma_enable = 8'h00;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    cyc(5);
    rst_b = 1;
    cyc(1);
    chk("reset flag", 16'h0000, {8'h00, flag_q});
    chk("reset dma", 16'h0000, {15'h0, dma_mode_q});
    t_mask();
    t_prio();
    t_nmi();
    t_di_ret();
    t_dma(1'b0);
    t_dma(1'b1);
    final_report();
  end
endmodule
bind pviu_core pviu_core_monitor mon (.clk_sys, .rst_b,
  .last_bus_cycle_end, .enable_irq_instruction, .disable_irq_instruction,
  .irq_return_instruction, .popped_flags, .flag_q, .irq_enable_flag,
  .accept_q, .vector_q, .dma_mode_q, .param_addr_q, .param_len_q,
  .bus_dummy_q, .push_pc_flags_q, .jump_q, .jump_addr_q, .busy);
